/* File: src/clk_switch_pkg.sv */
// Shared constants for the clock switch and fail-safe controller.
// Assumes a single 125 MHz reference clock and a Wishbone register bus.
`default_nettype none
package clk_switch_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] OSC_CTRL_IDX = 16'h0742;
  localparam logic [15:0] AUX_CTRL_IDX = 16'h074A;
  localparam logic [15:0] CFG_IDX = 16'h0750;
  // Reset values and the aux write mask.
  localparam logic [15:0] OSC_CTRL_RST = 16'h7700;
  localparam logic [15:0] AUX_CTRL_RST = 16'h0000;
  localparam logic [15:0] AUX_WR_MASK = 16'h3F80;
  localparam logic [2:0] CFG_RST = 3'h3;
  // Field positions in the oscillator and auxiliary control registers.
  localparam int CUR_SEL_LSB = 12;
  localparam int NEW_SEL_LSB = 8;
  localparam int LOCK_BIT = 7;
  localparam int PLL_STAT_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int REQ_BIT = 0;
  localparam int AUX_PS_LSB = 8;
  // Unlock keys for the upper and lower control bytes.
  localparam logic [7:0] HI_KEY1 = 8'h78;
  localparam logic [7:0] HI_KEY2 = 8'h9A;
  localparam logic [7:0] LO_KEY1 = 8'h46;
  localparam logic [7:0] LO_KEY2 = 8'h57;
  // Oscillator selection codes and the aux divide-by-one postscale code.
  localparam logic [2:0] SEL_FAST_RC = 3'h0;
  localparam logic [2:0] SEL_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRIMARY = 3'h2;
  localparam logic [2:0] SEL_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SEL_SECONDARY = 3'h4;
  localparam logic [2:0] SEL_LOW_RC = 3'h5;
  localparam logic [2:0] PS_DIV1 = 3'h7;
  // Switch-mode configuration codes.
  localparam logic [1:0] MODE_BOTH = 2'h0;
  localparam logic [1:0] MODE_SWITCH_ONLY = 2'h1;
  // Oscillator enable bit positions.
  localparam int EN_PRIMARY = 0;
  localparam int EN_SECONDARY = 1;
  localparam int EN_FAST_RC = 2;
  localparam int EN_LOW_RC = 3;
  // Timing.
  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam int FAIL_WINDOW_MS = 2;
  localparam int FAIL_WINDOW_MAX_MS = 4;
  localparam int FAIL_WINDOW_CYC = int'(FAIL_WINDOW_MS * CLK_FREQ_HZ / 1000);
  localparam int MON_DELAY_CYC = 1024;
  localparam int OST_CYC = 1024;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } fsm_type;
endpackage : clk_switch_pkg
`default_nettype wire

/* File: src/clock_switch_failsafe_ctrl.sv */
// Clock source switch controller, fail-safe monitor and aux postscaler.
// Assumes a classic Wishbone master, oscillators that report readiness
// asynchronously, and a core that drives the sleep level on this clock.
//
// What this block does
// - Aux postscaler codes 111..001, 000 divides 256
// - Mode 00 keeps low-power RC running while awake
// - Missing system clock traps, falls to fast RC
// - Fallback loads current selection with 000
// - Fallback sets clock fail flag
// - Fallback clears switch request
// - Failure in sleep never wakes device
// - Monitor starts after ready and start delay
// - Watchdog low-power RC unaffected by failure
// - Mode 1x off, 01 switch, 00 both
// - Request switches to new selection when ready
// - Make before break; old clock held
// - Control register protected during switch
// - Equal selections drop redundant request
// - Valid start clears lock status, fail flag
// - Wait start-up timer and PLL lock
// - Completion clears request, copies new selection
// - Stop old source except kept ones
// - Lock bit blocks mode 01; power-on clears
// - Unlock opens byte for one write
// - Clearing request aborts, resets start-up timer
// - Sleep during switch aborts it
`timescale 1ns/1ps
`default_nettype none
module clock_switch_failsafe_ctrl
  import clk_switch_pkg::*;
#(
  parameter int FAIL_CYC = FAIL_WINDOW_CYC,
  parameter int MON_DLY = MON_DELAY_CYC,
  parameter int OST_LEN = OST_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic POR_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SLEEP_I,
  input wire logic [3:0] OSC_READY_I,
  input wire logic PLL_LOCK_I,
  input wire logic SYS_CLK_ACT_I,
  input wire logic AUX_CLK_I,
  output logic [3:0] OSC_EN_O,
  output logic PLL_EN_O,
  output logic [2:0] SYS_CLK_SEL_O,
  output logic CLK_FAIL_TRAP_O,
  output logic AUX_CLK_O
);

  // Map a selection code to the oscillator that feeds it.
  function automatic logic [1:0] src_of(input logic [2:0] sel);
    case (sel)
      SEL_PRIMARY, SEL_PRIMARY_PLL: src_of = 2'(EN_PRIMARY);
      SEL_SECONDARY: src_of = 2'(EN_SECONDARY);
      SEL_LOW_RC: src_of = 2'(EN_LOW_RC);
      default: src_of = 2'(EN_FAST_RC);
    endcase
  endfunction : src_of

  function automatic logic uses_pll(input logic [2:0] sel);
    uses_pll = (sel == SEL_FAST_RC_PLL) || (sel == SEL_PRIMARY_PLL);
  endfunction : uses_pll

  // Crystal sources need the start-up timer and the monitor delay.
  function automatic logic is_xtal(input logic [2:0] sel);
    is_xtal = (src_of(sel) == 2'(EN_PRIMARY)) ||
              (src_of(sel) == 2'(EN_SECONDARY));
  endfunction : is_xtal

  logic rst;
  logic [6:0] s1_r, s2_r;
  logic act_d_r, aux_d_r;
  logic [3:0] rdy_s;
  logic lock_s, act_s, aux_s;
  logic ack_r;
  logic [31:0] dat_r;
  logic req, do_wr, osc_hit, aux_hit, cfg_hit;
  logic hi_wr, lo_wr, hi_acc, lo_acc;
  logic [1:0] hi_step_r, lo_step_r;
  fsm_type state_r;
  logic [2:0] cur_sel_r, new_sel_r;
  logic req_r, fail_r, lock_bit_r, sec_en_r, pll_stat_r;
  logic [1:0] mode_r;
  logic wdt_en_r;
  logic [15:0] aux_r;
  logic [31:0] ost_r, dly_r, win_r;
  logic fail_pulse_r;
  logic busy, switch_ok, new_ready, mon_on, mon_go, sleep;
  logic [7:0] aux_cnt_r, aux_half;
  logic aux_out_r;

  assign rst = RESET_I | POR_I;
  assign sleep = SLEEP_I;

  // Two-flop synchronisers for every asynchronous input.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
      act_d_r <= 1'b0;
      aux_d_r <= 1'b0;
    end else begin
      s1_r <= {AUX_CLK_I, SYS_CLK_ACT_I, PLL_LOCK_I, OSC_READY_I};
      s2_r <= s1_r;
      act_d_r <= s2_r[5];
      aux_d_r <= s2_r[6];
    end
  end
  assign rdy_s = s2_r[3:0];
  assign lock_s = s2_r[4];
  assign act_s = s2_r[5];
  assign aux_s = s2_r[6];

  // Wishbone decode; every access is answered one cycle later.
  assign req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign do_wr = req & WB_WE_I;
  assign osc_hit = {2'b00, WB_ADR_I[15:2]} == OSC_CTRL_IDX;
  assign aux_hit = {2'b00, WB_ADR_I[15:2]} == AUX_CTRL_IDX;
  assign cfg_hit = {2'b00, WB_ADR_I[15:2]} == CFG_IDX;
  assign hi_wr = do_wr & osc_hit & WB_SEL_I[1];
  assign lo_wr = do_wr & osc_hit & WB_SEL_I[0];
  assign hi_acc = hi_wr & (hi_step_r == 2'd2);
  assign lo_acc = lo_wr & (lo_step_r == 2'd2);
  assign busy = state_r != ST_IDLE;
  assign switch_ok = ~mode_r[1] &
                     ~(lock_bit_r & (mode_r == MODE_SWITCH_ONLY));

  // Bus answer; unmapped addresses read zero and still acknowledge.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req & ~WB_WE_I) begin
        dat_r <= 32'h0000_0000;
        if (osc_hit)
          dat_r[15:0] <= {1'b0, cur_sel_r, 1'b0, new_sel_r, lock_bit_r,
                          1'b0, pll_stat_r, 1'b0, fail_r, 1'b0,
                          sec_en_r, req_r};
        if (aux_hit)
          dat_r[15:0] <= aux_r;
        if (cfg_hit)
          dat_r[6:0] <= {mon_go, state_r, 1'b0, wdt_en_r, mode_r};
      end
    end
  end
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // Unlock trackers: any write that breaks the pair disarms the byte,
  // so the key pair must be the last two writes before the real one.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      hi_step_r <= 2'd0;
      lo_step_r <= 2'd0;
    end else if (do_wr) begin
      if (hi_wr & ~hi_acc & (WB_DAT_I[15:8] == HI_KEY1))
        hi_step_r <= 2'd1;
      else if (hi_wr & (hi_step_r == 2'd1) &
               (WB_DAT_I[15:8] == HI_KEY2))
        hi_step_r <= 2'd2;
      else
        hi_step_r <= 2'd0;
      if (lo_wr & ~lo_acc & (WB_DAT_I[7:0] == LO_KEY1))
        lo_step_r <= 2'd1;
      else if (lo_wr & (lo_step_r == 2'd1) &
               (WB_DAT_I[7:0] == LO_KEY2))
        lo_step_r <= 2'd2;
      else
        lo_step_r <= 2'd0;
    end
  end

  // The lock bit is set-only and survives every reset but power-on.
  always_ff @(posedge REF_CLK_I) begin
    if (POR_I) begin
      lock_bit_r <= OSC_CTRL_RST[LOCK_BIT];
    end else if (lo_acc & ~busy & WB_DAT_I[LOCK_BIT]) begin
      lock_bit_r <= 1'b1;
    end
  end

  // Configuration and auxiliary control registers.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      mode_r <= CFG_RST[1:0];
      wdt_en_r <= CFG_RST[2];
      aux_r <= AUX_CTRL_RST;
    end else begin
      if (do_wr & cfg_hit & WB_SEL_I[0]) begin
        mode_r <= WB_DAT_I[1:0];
        wdt_en_r <= WB_DAT_I[2];
      end
      if (do_wr & aux_hit & WB_SEL_I[1])
        aux_r[15:8] <= WB_DAT_I[15:8] & AUX_WR_MASK[15:8];
      if (do_wr & aux_hit & WB_SEL_I[0])
        aux_r[7:0] <= WB_DAT_I[7:0] & AUX_WR_MASK[7:0];
    end
  end

  // Readiness of the requested source.
  // timer and lock wait
  assign new_ready = rdy_s[src_of(new_sel_r)] & (ost_r == 32'd0) &
                     (~uses_pll(new_sel_r) | lock_s);

  // Switch sequencer and oscillator control state. A fallback outranks
  // every software and sequencer action in the same cycle.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cur_sel_r <= OSC_CTRL_RST[CUR_SEL_LSB +: 3];
      new_sel_r <= OSC_CTRL_RST[NEW_SEL_LSB +: 3];
      req_r <= OSC_CTRL_RST[REQ_BIT];
      fail_r <= OSC_CTRL_RST[FAIL_BIT];
      sec_en_r <= OSC_CTRL_RST[SEC_EN_BIT];
      pll_stat_r <= OSC_CTRL_RST[PLL_STAT_BIT];
      ost_r <= 32'd0;
    end else if (fail_pulse_r) begin
      cur_sel_r <= SEL_FAST_RC;
      fail_r <= 1'b1;
      req_r <= 1'b0;
      state_r <= ST_IDLE;
      ost_r <= 32'd0;
      pll_stat_r <= lock_s;
    end else begin
      pll_stat_r <= lock_s;
      if (hi_acc & ~busy & ~req_r)
        new_sel_r <= WB_DAT_I[NEW_SEL_LSB +: 3];
      if (lo_acc & ~busy & ~req_r) begin
        sec_en_r <= WB_DAT_I[SEC_EN_BIT];
        req_r <= WB_DAT_I[REQ_BIT] & switch_ok;
      end else if (lo_acc & ~WB_DAT_I[REQ_BIT]) begin
        req_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (req_r)
            state_r <= ST_CHECK;
        end
        ST_CHECK: begin
          if (new_sel_r == cur_sel_r) begin
            req_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            fail_r <= 1'b0;
            pll_stat_r <= 1'b0;
            ost_r <= is_xtal(new_sel_r) ? 32'(OST_LEN) : 32'd0;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (~req_r | sleep) begin
            req_r <= 1'b0;
            ost_r <= 32'd0;
            state_r <= ST_IDLE;
          end else if (new_ready) begin
            state_r <= ST_DONE;
          end else if (ost_r != 32'd0) begin
            ost_r <= ost_r - 32'd1;
          end
        end
        ST_DONE: begin
          cur_sel_r <= new_sel_r;
          req_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // The monitor runs only when enabled, awake and on a ready clock, so
  // a failure during sleep is never seen and cannot wake the device.
  // no wake in sleep
  assign mon_on = (mode_r == MODE_BOTH) & ~sleep &
                  rdy_s[src_of(cur_sel_r)];
  assign mon_go = mon_on & (dly_r == 32'd0);

  // Fail-safe monitor: start delay, then a window with no activity edge.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      dly_r <= 32'd0;
      win_r <= 32'd0;
      fail_pulse_r <= 1'b0;
    end else begin
      fail_pulse_r <= 1'b0;
      if (~mon_on | fail_pulse_r | (state_r == ST_DONE)) begin
        dly_r <= is_xtal(cur_sel_r) ? 32'(MON_DLY) : 32'd0;
        win_r <= 32'd0;
      end else if (dly_r != 32'd0) begin
        dly_r <= dly_r - 32'd1;
      end else if (act_s ^ act_d_r) begin
        win_r <= 32'd0;
      end else if (win_r == 32'(FAIL_CYC - 1)) begin
        fail_pulse_r <= 1'b1;
        win_r <= 32'd0;
      end else begin
        win_r <= win_r + 32'd1;
      end
    end
  end
  assign CLK_FAIL_TRAP_O = fail_pulse_r;

  // Oscillator enables. The current source stays on until the switch
  // commits, so the new one is up before the old one drops.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      OSC_EN_O <= 4'h0;
      PLL_EN_O <= 1'b0;
      SYS_CLK_SEL_O <= OSC_CTRL_RST[CUR_SEL_LSB +: 3];
    end else begin
      SYS_CLK_SEL_O <= cur_sel_r;
      for (int k = 0; k < 4; k++) begin
        OSC_EN_O[k] <= ~sleep & ((src_of(cur_sel_r) == 2'(k)) |
                       (busy & (src_of(new_sel_r) == 2'(k))));
      end
      if (sec_en_r)
        OSC_EN_O[EN_SECONDARY] <= 1'b1;
      if (wdt_en_r | (~sleep & (mode_r == MODE_BOTH)))
        OSC_EN_O[EN_LOW_RC] <= 1'b1;
      PLL_EN_O <= ~sleep & (uses_pll(cur_sel_r) |
                  ((state_r == ST_WAIT) & uses_pll(new_sel_r)));
    end
  end

  // Half period, in aux edges, for each postscale code.
  // postscale decode
  always_comb begin
    aux_half = 8'd128;
    if (aux_r[AUX_PS_LSB +: 3] != 3'h0)
      aux_half = 8'(8'd1 << (3'd6 - aux_r[AUX_PS_LSB +: 3]));
  end

  // Aux postscaler; divide by one passes the synchronised clock.
  always_ff @(posedge REF_CLK_I) begin
    if (rst) begin
      aux_cnt_r <= 8'd0;
      aux_out_r <= 1'b0;
    end else if (aux_r[AUX_PS_LSB +: 3] == PS_DIV1) begin
      aux_cnt_r <= 8'd0;
      aux_out_r <= aux_s;
    end else if (aux_s & ~aux_d_r) begin
      if (aux_cnt_r >= aux_half - 8'd1) begin
        aux_cnt_r <= 8'd0;
        aux_out_r <= ~aux_out_r;
      end else begin
        aux_cnt_r <= aux_cnt_r + 8'd1;
      end
    end
  end
  assign AUX_CLK_O = aux_out_r;

endmodule : clock_switch_failsafe_ctrl
`default_nettype wire

/* File: dv/clk_switch_checker_properties.sv */
// Concurrent checks on the clock switch controller's ports.
// Assumes one clock domain and the two active high resets.
`timescale 1ns/1ps
`default_nettype none
module clk_switch_checker
  import clk_switch_pkg::*;
#(
  parameter int FAIL_CYC = 64
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic POR_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic SLEEP_I,
  input wire logic [3:0] OSC_READY_I,
  input wire logic SYS_CLK_ACT_I,
  input wire logic [3:0] OSC_EN_O,
  input wire logic [2:0] SYS_CLK_SEL_O,
  input wire logic CLK_FAIL_TRAP_O
);
  logic act_q;
  int idle_cnt;
  // Idle span of the raw activity input; the design's synchroniser only
  // delays edges, so the raw span is never shorter than the one it sees.
  always_ff @(posedge REF_CLK_I) begin
    act_q <= SYS_CLK_ACT_I;
    if (RESET_I || POR_I || SYS_CLK_ACT_I != act_q) begin
      idle_cnt <= 0;
    end else begin
      idle_cnt <= idle_cnt + 1;
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I || POR_I);
  sequence take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence trap_seen;
    CLK_FAIL_TRAP_O;
  endsequence
  a_ack_next: assert property (take |=> WB_ACK_O)
    else $error("ack missing after a request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (take and !WB_WE_I
      and WB_ADR_I == 16'h0004 |=> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_trap_to_fast: assert property (
      trap_seen |-> ##[1:2] SYS_CLK_SEL_O == SEL_FAST_RC)
    else $error("no fallback to fast RC after trap");
  a_trap_single: assert property (trap_seen |=> !CLK_FAIL_TRAP_O)
    else $error("trap longer than one cycle");
  a_trap_idle_span: assert property (
      trap_seen |-> idle_cnt >= FAIL_CYC)
    else $error("trap before the detection window ran out");
  a_fast_rc_on: assert property (
      trap_seen |-> ##[1:3] OSC_EN_O[EN_FAST_RC])
    else $error("fast RC not enabled after trap");
  a_sleep_no_trap: assert property (
      $past(SLEEP_I) && $past(SLEEP_I, 2) |-> !CLK_FAIL_TRAP_O)
    else $error("trap raised in sleep");
  a_make_before_break: assert property (
      $changed(SYS_CLK_SEL_O) && SYS_CLK_SEL_O == SEL_PRIMARY
      |-> $past(OSC_EN_O[EN_PRIMARY]) && $past(OSC_READY_I[EN_PRIMARY], 4))
    else $error("switched to a source not yet ready");
  a_old_kept: assert property (
      $changed(SYS_CLK_SEL_O) && $past(SYS_CLK_SEL_O) == SEL_FAST_RC
      |-> $past(OSC_EN_O[EN_FAST_RC]))
    else $error("old source stopped before the switch");
endmodule : clk_switch_checker
bind clock_switch_failsafe_ctrl clk_switch_checker #(.FAIL_CYC(FAIL_CYC))
  clk_switch_checker_i (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
  .POR_I(POR_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .SLEEP_I(SLEEP_I), .OSC_READY_I(OSC_READY_I),
  .SYS_CLK_ACT_I(SYS_CLK_ACT_I), .OSC_EN_O(OSC_EN_O),
  .SYS_CLK_SEL_O(SYS_CLK_SEL_O), .CLK_FAIL_TRAP_O(CLK_FAIL_TRAP_O));
`default_nettype wire

/* File: dv/clock_switch_failsafe_ctrl_tb_top.sv */
// Self-checking bench for the clock switch and fail-safe controller.
// Assumes the design package; the bench is the Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module clock_switch_failsafe_ctrl_tb_top
  import clk_switch_pkg::*;
;
  localparam logic [15:0] osc_a = {OSC_CTRL_IDX[13:0], 2'b00};
  localparam logic [15:0] aux_a = {AUX_CTRL_IDX[13:0], 2'b00};
  localparam logic [15:0] cfg_a = {CFG_IDX[13:0], 2'b00};
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, sleep = 1'b0, act = 1'b0, aux_in = 1'b0, aux_ph = 1'b0;
  logic act_run = 1'b0, aux_q = 1'b0, pll_lock = 1'b0;
  logic ack, pll_en, trap, aux_out;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0, rdy = 4'hC, osc_en;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic [2:0] sys_sel;
  int mismatches = 0, cmp_count = 0, trap_cnt = 0, aux_rise = 0;
  clock_switch_failsafe_ctrl #(.FAIL_CYC(64), .MON_DLY(8), .OST_LEN(8))
  clock_switch_failsafe_ctrl_i (.REF_CLK_I(clk), .RESET_I(rst),
    .POR_I(por), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SLEEP_I(sleep), .OSC_READY_I(rdy),
    .PLL_LOCK_I(pll_lock), .SYS_CLK_ACT_I(act), .AUX_CLK_I(aux_in),
    .OSC_EN_O(osc_en), .PLL_EN_O(pll_en), .SYS_CLK_SEL_O(sys_sel),
    .CLK_FAIL_TRAP_O(trap), .AUX_CLK_O(aux_out));
  always #4 clk = ~clk;
  // Activity and aux sources; the aux clock has a four-cycle period.
  always @(posedge clk) begin
    if (act_run) act <= ~act;
    aux_ph <= ~aux_ph;
    if (aux_ph) aux_in <= ~aux_in;
  end
  // Count trap pulses and divided aux rising edges.
  always @(posedge clk) begin
    aux_q <= aux_out;
    if (aux_out && !aux_q) aux_rise++;
    if (trap === 1'b1) trap_cnt++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks
  // One classic cycle; ack and read data are taken at the same edge.
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check({15'h0000, ack}, 16'h0001);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [15:0] a);
    wb(1'b0, a, 4'hF, 32'h0000_0000);
  endtask : rd
  // Two key writes on one lane, then the value itself.
  // key pair, then value
  task automatic put(input logic hi, input logic [7:0] v);
    logic [3:0] s;
    s = hi ? 4'h2 : 4'h1;
    wb(1'b1, osc_a, s, {16'h0000, {2{hi ? HI_KEY1 : LO_KEY1}}});
    wb(1'b1, osc_a, s, {16'h0000, {2{hi ? HI_KEY2 : LO_KEY2}}});
    wb(1'b1, osc_a, s, {16'h0000, v, v});
  endtask : put
  // Poll the request bit the way software would, with a bound.
  task automatic settle();
    int n;
    n = 0;
    rd(osc_a);
    while (q[REQ_BIT] !== 1'b0 && n < 100) begin
      rd(osc_a);
      n++;
    end
  endtask : settle
  // Reset values, disabled mode and unlock gating.
  task automatic t_regs();
    rd(osc_a);
    check(q[15:0], OSC_CTRL_RST);
    rd(cfg_a);
    check(q[15:0], {13'h0000, CFG_RST});
    rd(16'h0004);
    check(q[15:0], 16'h0000);
    put(1'b0, 8'h01);
    rd(osc_a);
    check(q[15:0], OSC_CTRL_RST);
    wb(1'b1, osc_a, 4'h2, 32'h0000_0200);
    rd(osc_a);
    check(q[15:0], OSC_CTRL_RST);
    put(1'b1, {5'h00, SEL_FAST_RC});
    wb(1'b1, osc_a, 4'h2, 32'h0000_0200);
    rd(osc_a);
    check(q[15:0], 16'h7000);
  endtask : t_regs
  task automatic t_switch();
    wb(1'b1, cfg_a, 4'h1, 32'h0000_0001);
    put(1'b0, 8'h01);
    settle();
    check(q[15:0], 16'h0000);
    check({13'h0000, sys_sel}, {13'h0000, SEL_FAST_RC});
    put(1'b0, 8'h01);
    settle();
    check(q[15:0], 16'h0000);
    put(1'b1, {5'h00, SEL_PRIMARY});
    put(1'b0, 8'h01);
    ticks(20);
    check({12'h000, osc_en}, 16'h0005);
    put(1'b1, {5'h00, SEL_SECONDARY});
    rd(osc_a);
    check(q[15:0], 16'h0201);
    check({13'h0000, sys_sel}, {13'h0000, SEL_FAST_RC});
    put(1'b0, 8'h00);
    rd(osc_a);
    check(q[15:0], 16'h0200);
    rdy <= 4'hD;
    put(1'b0, 8'h01);
    settle();
    check(q[15:0], 16'h2200);
    ticks(4);
    check({12'h000, osc_en}, 16'h0001);
  endtask : t_switch
  task automatic t_failsafe();
    int n;
    act_run <= 1'b1;
    wb(1'b1, cfg_a, 4'h1, 32'h0000_0000);
    ticks(4);
    check({15'h0000, osc_en[EN_LOW_RC]}, 16'h0001);
    wb(1'b1, cfg_a, 4'h1, 32'h0000_0004);
    put(1'b1, {5'h00, SEL_SECONDARY});
    put(1'b0, 8'h01);
    ticks(100);
    check(trap_cnt[15:0], 16'h0000);
    sleep <= 1'b1;
    act_run <= 1'b0;
    ticks(150);
    check(trap_cnt[15:0], 16'h0000);
    rd(osc_a);
    check(q[15:0], 16'h2400);
    sleep <= 1'b0;
    act_run <= 1'b1;
    put(1'b0, 8'h01);
    act_run <= 1'b0;
    n = 0;
    while (trap_cnt == 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    act_run <= 1'b1;
    check({15'h0000, n >= 64 && n <= 128}, 16'h0001);
    ticks(2);
    rd(osc_a);
    check(q[15:0], 16'h0408);
    check({15'h0000, osc_en[EN_LOW_RC]}, 16'h0001);
    put(1'b0, 8'h01);
    rd(osc_a);
    check(q[15:0], 16'h0401);
    put(1'b0, 8'h00);
  endtask : t_failsafe
  // Lock bit blocks switching and survives a device reset.
  task automatic t_lock();
    rdy <= 4'hF;
    wb(1'b1, cfg_a, 4'h1, 32'h0000_0001);
    put(1'b0, 8'h80);
    put(1'b1, {5'h00, SEL_LOW_RC});
    put(1'b0, 8'h81);
    ticks(20);
    put(1'b0, 8'h00);
    rd(osc_a);
    check(q[15:0], 16'h0580);
    rst <= 1'b1;
    ticks(2);
    rst <= 1'b0;
    ticks(2);
    rd(osc_a);
    check(q[15:0], 16'h7780);
    por <= 1'b1;
    ticks(2);
    por <= 1'b0;
    ticks(2);
    rd(osc_a);
    check(q[15:0], OSC_CTRL_RST);
  endtask : t_lock
  // A PLL source waits for lock; only one PLL source used.
  task automatic t_pll();
    wb(1'b1, cfg_a, 4'h1, 32'h0000_0001);
    put(1'b1, {5'h00, SEL_FAST_RC_PLL});
    put(1'b0, 8'h01);
    ticks(20);
    check({15'h0000, pll_en}, 16'h0001);
    rd(osc_a);
    check(q[15:0], 16'h7101);
    pll_lock <= 1'b1;
    settle();
    check(q[15:0], 16'h1120);
    check({13'h0000, sys_sel}, {13'h0000, SEL_FAST_RC_PLL});
  endtask : t_pll
  // Every postscale code over 256 aux periods, one edge of slack.
  task automatic t_aux();
    int base, d, e;
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, aux_a, 4'h2, {21'h00_0000, c[2:0], 8'h00});
      rd(aux_a);
      check(q[15:0], {5'h00, c[2:0], 8'h00});
      ticks(16);
      base = aux_rise;
      ticks(1024);
      d = aux_rise - base;
      e = (c == 0) ? 1 : 256 >> (7 - c);
      check({15'h0000, d >= e - 1 && d <= e + 1}, 16'h0001);
    end
  endtask : t_aux
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // Main sequence after a four-cycle reset.
  initial begin
    ticks(4);
    rst <= 1'b0;
    por <= 1'b0;
    ticks(2);
    t_regs();
    t_switch();
    t_failsafe();
    t_lock();
    t_pll();
    t_aux();
    conclude();
  end
  // Watchdog well past the expected run of about 9000 cycles.
  initial begin
    ticks(40000);
    mismatches++;
    conclude();
  end
endmodule : clock_switch_failsafe_ctrl_tb_top
`default_nettype wire
